// ### src/csq_pkg.sv
// Shared constants, states and carriers of the capture sequencer.
// Assumes it is compiled ahead of both design files.
package csq_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    // Channels in one sampled word.
    localparam int CH_W = 16;
    // Capture depth in words of the large and the small build.
    localparam int DEPTH_LARGE = 16384;
    localparam int DEPTH_SMALL = 1024;
    // Word pointer width; it must hold DEPTH_LARGE itself.
    localparam int PTR_W = 15;
    // Pointer step and the address of the first stored word.
    localparam logic [PTR_W-1:0] PTR_ONE = 15'h0001;
    localparam logic [PTR_W-1:0] FIRST_ADDR = 15'h0000;
    // Transitions within one sample period that make a glitch.
    localparam logic [1:0] GLITCH_MIN = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Operating modes.
    typedef enum logic [1:0] {
        CSQ_TRG_START = 2'b00,
        CSQ_TRG_STOP = 2'b01,
        CSQ_CMP = 2'b10
    } csq_mode_e;

    // Sequencer states, gray ordered so the state word can cross.
    typedef enum logic [1:0] {
        CSQ_IDLE = 2'b00,
        CSQ_ARMED = 2'b01,
        CSQ_ACTIVE = 2'b11,
        CSQ_DONE = 2'b10
    } csq_state_e;

    // Configuration word kept in the control domain.
    typedef struct packed {
        csq_mode_e mode;
        logic glitch_en;
        logic clk_src_ext;
        logic dual_thr;
    } csq_cfg_s;

    // Settings after a restore of the defaults.
    localparam csq_cfg_s CFG_DEFAULT = '{
        mode: CSQ_TRG_START, glitch_en: 1'b0,
        clk_src_ext: 1'b1, dual_thr: 1'b0
    };

    // One sample: data plus per-channel transition counts seen on
    // the upper (or single) and lower threshold since the last edge.
    typedef struct packed {
        logic [CH_W-1:0] data;
        logic [CH_W-1:0][1:0] tr_up;
        logic [CH_W-1:0][1:0] tr_lo;
    } csq_smp_s;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Binary to gray for the pointer crossing.
    function automatic logic [PTR_W-1:0] bin2gray(
        input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    // Gray back to binary on the receiving side.
    function automatic logic [PTR_W-1:0] gray2bin(
        input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    // True when a transition count marks a glitch.
    function automatic logic multi_tr(input logic [1:0] c);
        return c >= GLITCH_MIN;
    endfunction : multi_tr

endpackage : csq_pkg

// ### src/csq_mem.sv
// Capture memory: two halves of N words each.
// Port a writes and reads on the sampling clock; port b reads only,
// on the control clock, so each half has a single writer.
`timescale 1ns/1ns
module csq_mem #(
    parameter int W = 16,
    parameter int N = 8192,
    parameter int AW = $clog2(N)
) (
    input wire logic a_clk,
    input wire logic a_en,
    input wire logic [1:0] a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [2*W-1:0] a_wdata,
    output logic [2*W-1:0] a_rdata,
    input wire logic b_clk,
    input wire logic b_rst,
    input wire logic b_en,
    input wire logic [AW-1:0] b_addr,
    input wire logic b_half,
    output logic [W-1:0] b_rdata
);
    // ------------------------------------------------------------
    // Storage, one array per half
    // ------------------------------------------------------------
    logic [W-1:0] rd_b [2]; // Asynchronous peek, registered below.
    for (genvar h = 0; h < 2; h++) begin : g_half
        logic [W-1:0] mem_r [N]; // Array of this half.
        // Port a write and registered read of this half.
        always_ff @(posedge a_clk) begin
            if (a_en) begin
                if (a_we[h]) begin
                    mem_r[a_addr] <= a_wdata[h*W +: W];
                end
                a_rdata[h*W +: W] <= mem_r[a_addr];
            end
        end
        assign rd_b[h] = mem_r[b_addr];
    end

    // ------------------------------------------------------------
    // Port b read register
    // ------------------------------------------------------------
    // Reset keeps the host output defined before the first read.
    always_ff @(posedge b_clk or posedge b_rst) begin
        if (b_rst) begin
            b_rdata <= '0;
        end else if (b_en) begin
            b_rdata <= b_half ? rd_b[1] : rd_b[0];
        end
    end
endmodule : csq_mem

// ### src/csq_capture_seq.sv
// Capture sequencer: run and arm control, sampling, addressing,
// glitch marking and real-time compare against stored words.
// Assumes smp_clk is the sampling clock chosen by a board mux that
// cfg_out.clk_src_ext steers; trig_hit and stop_hit come from
// condition logic on smp_clk; smp_in is timed to smp_clk.
//
// Notes on behaviour
// - Start mode waits armed, samples after trigger.
// - Start mode stop hit returns to idle.
// - Memory holds 16384 or 1024 words.
// - Trigger word at address zero, then ascending.
// - Stop mode goes active on first clock.
// - Stop mode samples until trigger, then idle.
// - Trigger word last, earlier words count backwards.
// - Input ignored after stop capture until rearmed.
// - Compare mode checks words, writes none.
// - Compare mode arms like start mode.
// - Two transitions per period flag a glitch.
// - Glitch flagged on single, upper or lower.
// - Glitch stored with data at next edge.
// - Glitch detection halves usable capacity.
// - Glitch detection forced off in compare.
// - Defaults disable glitch detection.
// - Defaults select the external clock.
`timescale 1ns/1ns
module csq_capture_seq #(
    parameter int DEPTH = csq_pkg::DEPTH_LARGE
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic cfg_wr,
    input wire csq_pkg::csq_cfg_s cfg_in,
    input wire logic load_defaults,
    input wire logic run_cmd,
    input wire logic host_rd,
    input wire logic [$clog2(DEPTH)-1:0] host_addr,
    output logic [csq_pkg::CH_W-1:0] host_rdata,
    output csq_pkg::csq_cfg_s cfg_out,
    output csq_pkg::csq_state_e status,
    output logic [csq_pkg::PTR_W-1:0] stored_words,
    output logic [csq_pkg::PTR_W-1:0] last_addr,
    output logic cmp_fail,
    input wire logic smp_clk,
    input wire csq_pkg::csq_smp_s smp_in,
    input wire logic trig_hit,
    input wire logic stop_hit
);
    localparam int W = csq_pkg::CH_W;
    localparam int PW = csq_pkg::PTR_W;
    localparam int HALF = DEPTH / 2;
    localparam int EW = $clog2(HALF);
    localparam logic [PW-1:0] CAP_FULL = PW'(DEPTH);
    localparam logic [PW-1:0] CAP_GL = PW'(HALF);

    // A depth the pointers cannot serve is refused here.
    if (DEPTH > csq_pkg::DEPTH_LARGE || DEPTH < 4 ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two from 4 to 16384");
    end

    // ------------------------------------------------------------
    // Control domain: configuration and run request
    // ------------------------------------------------------------
    csq_pkg::csq_cfg_s cfg_r;  // Live configuration.
    logic run_tgl_r;           // Flips once per accepted run.

    // Config writes land only while idle; defaults load in any state and override a write.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_r <= csq_pkg::CFG_DEFAULT;
        end else if (ce) begin
            if (load_defaults) begin
                cfg_r <= csq_pkg::CFG_DEFAULT;
            end else if (cfg_wr && status == csq_pkg::CSQ_IDLE) begin
                cfg_r <= cfg_in;
                // Compare leaves no room for glitch words.
                cfg_r.glitch_en <= cfg_in.glitch_en &&
                    cfg_in.mode != csq_pkg::CSQ_CMP;
            end
        end
    end
    assign cfg_out = cfg_r;

    // A run is an event, so it crosses as a toggle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_tgl_r <= 1'b0;
        end else if (ce && run_cmd && status == csq_pkg::CSQ_IDLE) begin
            run_tgl_r <= ~run_tgl_r;
        end
    end

    // ------------------------------------------------------------
    // Link domain: synchronisers
    // ------------------------------------------------------------
    logic ce_m_l, ce_s_l;                // Clock enable.
    csq_pkg::csq_cfg_s cfg_m_l, cfg_s_l; // Quasi-static config.
    logic rt_m_l, rt_s_l, rt_d_l;        // Run toggle and delay.
    logic run_go;                        // One-cycle run event.

    // Config writes land only while idle, so their bits are settled
    // long before a run toggle arrives behind them; defaults may load in any state.
    always_ff @(posedge smp_clk or posedge reset) begin
        if (reset) begin
            ce_m_l <= 1'b0;
            ce_s_l <= 1'b0;
            cfg_m_l <= csq_pkg::CFG_DEFAULT;
            cfg_s_l <= csq_pkg::CFG_DEFAULT;
            rt_m_l <= 1'b0;
            rt_s_l <= 1'b0;
        end else begin
            ce_m_l <= ce;
            ce_s_l <= ce_m_l;
            cfg_m_l <= cfg_r;
            cfg_s_l <= cfg_m_l;
            rt_m_l <= run_tgl_r;
            rt_s_l <= rt_m_l;
        end
    end

    // Edge detect of the run toggle; held while frozen.
    always_ff @(posedge smp_clk or posedge reset) begin
        if (reset) begin
            rt_d_l <= 1'b0;
        end else if (ce_s_l) begin
            rt_d_l <= rt_s_l;
        end
    end
    assign run_go = rt_s_l ^ rt_d_l;

    // ------------------------------------------------------------
    // Link domain: sample stage and glitch flags
    // ------------------------------------------------------------
    csq_pkg::csq_smp_s smp_r; // Sample taken at this edge.
    logic trg_r, stp_r;       // Conditions aligned with it.
    logic [W-1:0] gl_vec;     // Per-channel glitch flags.
    logic is_stop, is_cmp, gl_on;
    logic [PW-1:0] cap_l;     // Usable capacity this run.

    always_ff @(posedge smp_clk or posedge reset) begin
        if (reset) begin
            smp_r <= '0;
            trg_r <= 1'b0;
            stp_r <= 1'b0;
        end else if (ce_s_l) begin
            smp_r <= smp_in;
            trg_r <= trig_hit;
            stp_r <= stop_hit;
        end
    end

    // Counts cover the period ending at this edge, so a glitch
    // lands with the following sample.
    for (genvar i = 0; i < W; i++) begin : g_glitch
        assign gl_vec[i] = csq_pkg::multi_tr(smp_r.tr_up[i]) ||
            (cfg_s_l.dual_thr &&
             csq_pkg::multi_tr(smp_r.tr_lo[i]));
    end

    assign is_stop = cfg_s_l.mode == csq_pkg::CSQ_TRG_STOP;
    assign is_cmp = cfg_s_l.mode == csq_pkg::CSQ_CMP;
    assign gl_on = cfg_s_l.glitch_en && !is_cmp;
    assign cap_l = gl_on ? CAP_GL : CAP_FULL;

    // ------------------------------------------------------------
    // Link domain: sequencer
    // ------------------------------------------------------------
    csq_pkg::csq_state_e st_r, st_nxt;
    logic [PW-1:0] ptr_r, ptr_nxt;   // Next word address.
    logic wrap_r, wrap_nxt;          // Ring has wrapped once.
    logic wr, cmp_go;                // Store or compare now.
    logic [PW-1:0] ptr_inc, ring_inc;
    logic ring_last;

    assign ptr_inc = ptr_r + csq_pkg::PTR_ONE;
    assign ring_last = ptr_inc == cap_l;
    assign ring_inc = ring_last ? csq_pkg::FIRST_ADDR : ptr_inc;

    // Next state, pointer and memory strobes.
    always_comb begin
        st_nxt = st_r;
        ptr_nxt = ptr_r;
        wrap_nxt = wrap_r;
        wr = 1'b0;
        cmp_go = 1'b0;
        case (st_r)
            csq_pkg::CSQ_IDLE: begin
                // Samples are ignored here, also after a capture.
                if (run_go) begin
                    st_nxt = csq_pkg::CSQ_ARMED;
                    ptr_nxt = csq_pkg::FIRST_ADDR;
                    wrap_nxt = 1'b0;
                end
            end
            csq_pkg::CSQ_ARMED: begin
                if (is_stop) begin
                    // First edge after arming already samples.
                    wr = 1'b1;
                    ptr_nxt = ring_inc;
                    st_nxt = trg_r ? csq_pkg::CSQ_DONE
                                   : csq_pkg::CSQ_ACTIVE;
                end else if (trg_r) begin
                    // Trigger word goes to the first address.
                    wr = !is_cmp;
                    cmp_go = is_cmp;
                    ptr_nxt = ptr_inc;
                    st_nxt = csq_pkg::CSQ_ACTIVE;
                end
            end
            csq_pkg::CSQ_ACTIVE: begin
                if (is_stop) begin
                    // Ring write; trigger word is the last stored.
                    wr = 1'b1;
                    ptr_nxt = ring_inc;
                    wrap_nxt = wrap_r || ring_last;
                    if (trg_r) begin
                        st_nxt = csq_pkg::CSQ_DONE;
                    end
                end else if (stp_r) begin
                    st_nxt = csq_pkg::CSQ_DONE;
                end else begin
                    wr = !is_cmp;
                    cmp_go = is_cmp;
                    ptr_nxt = ptr_inc;
                    if (ring_last) begin
                        st_nxt = csq_pkg::CSQ_DONE;
                    end
                end
            end
            csq_pkg::CSQ_DONE: begin
                st_nxt = csq_pkg::CSQ_IDLE;
            end
            default: begin
                st_nxt = csq_pkg::CSQ_IDLE;
            end
        endcase
    end

    // Sequencer registers; reset lands in idle.
    always_ff @(posedge smp_clk or posedge reset) begin
        if (reset) begin
            st_r <= csq_pkg::CSQ_IDLE;
            ptr_r <= csq_pkg::FIRST_ADDR;
            wrap_r <= 1'b0;
        end else if (ce_s_l) begin
            st_r <= st_nxt;
            ptr_r <= ptr_nxt;
            wrap_r <= wrap_nxt;
        end
    end

    // ------------------------------------------------------------
    // Memory and compare
    // ------------------------------------------------------------
    logic [EW-1:0] a_addr;
    logic [1:0] a_we;
    logic [2*W-1:0] a_wdata, a_rdata;
    logic cmp_pend_r, cmp_half_r, cmp_fail_l;
    logic [W-1:0] cmp_dat_r, exp_word;

    // With glitch on, a sample takes a whole pair: data, flags.
    assign a_addr = gl_on ? ptr_r[EW-1:0] : ptr_r[EW:1];
    assign a_we = !wr ? 2'h0 : gl_on ? 2'h3
                : {ptr_r[0], !ptr_r[0]};
    assign a_wdata = gl_on ? {gl_vec, smp_r.data}
                           : {smp_r.data, smp_r.data};

    csq_mem #(
        .W(W),
        .N(HALF),
        .AW(EW)
    ) u_mem (
        .a_clk(smp_clk),
        .a_en((wr || cmp_go) && ce_s_l),
        .a_we(a_we),
        .a_addr(a_addr),
        .a_wdata(a_wdata),
        .a_rdata(a_rdata),
        .b_clk(clk),
        .b_rst(reset),
        .b_en(host_rd && ce),
        .b_addr(host_addr[EW:1]),
        .b_half(host_addr[0]),
        .b_rdata(host_rdata)
    );

    // Expected word arrives a cycle later; the sample waits for it.
    assign exp_word = cmp_half_r ? a_rdata[2*W-1:W] : a_rdata[W-1:0];
    always_ff @(posedge smp_clk or posedge reset) begin
        if (reset) begin
            cmp_pend_r <= 1'b0;
            cmp_half_r <= 1'b0;
            cmp_dat_r <= '0;
            cmp_fail_l <= 1'b0;
        end else if (ce_s_l) begin
            cmp_pend_r <= cmp_go;
            cmp_half_r <= ptr_r[0];
            cmp_dat_r <= smp_r.data;
            if (cmp_pend_r && exp_word != cmp_dat_r) begin
                cmp_fail_l <= 1'b1;
            end else if (run_go) begin
                cmp_fail_l <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Status back to the control domain
    // ------------------------------------------------------------
    logic [PW-1:0] pg_l, pg_m_r, pg_s_r, pb;
    logic [1:0] st_m_r, st_s_r;
    logic wr_m_r, wr_s_r, cf_m_r, cf_s_r;
    logic [PW-1:0] cap_c;

    // Gray pointer so one bit moves per step.
    always_ff @(posedge smp_clk or posedge reset) begin
        if (reset) begin
            pg_l <= '0;
        end else if (ce_s_l) begin
            pg_l <= csq_pkg::bin2gray(ptr_nxt);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pg_m_r <= '0;
            pg_s_r <= '0;
            st_m_r <= '0;
            st_s_r <= '0;
            wr_m_r <= 1'b0;
            wr_s_r <= 1'b0;
            cf_m_r <= 1'b0;
            cf_s_r <= 1'b0;
        end else begin
            pg_m_r <= pg_l;
            pg_s_r <= pg_m_r;
            st_m_r <= st_r;
            st_s_r <= st_m_r;
            wr_m_r <= wrap_r;
            wr_s_r <= wr_m_r;
            cf_m_r <= cmp_fail_l;
            cf_s_r <= cf_m_r;
        end
    end

    assign pb = csq_pkg::gray2bin(pg_s_r);
    assign cap_c = cfg_r.glitch_en ? CAP_GL : CAP_FULL;

    // Visible status; the done step reads as idle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status <= csq_pkg::CSQ_IDLE;
            stored_words <= '0;
            last_addr <= '0;
            cmp_fail <= 1'b0;
        end else if (ce) begin
            status <= (st_s_r == csq_pkg::CSQ_DONE)
                ? csq_pkg::CSQ_IDLE : csq_pkg::csq_state_e'(st_s_r);
            stored_words <= wr_s_r ? cap_c : pb;
            last_addr <= (pb == csq_pkg::FIRST_ADDR ? cap_c : pb)
                - csq_pkg::PTR_ONE;
            cmp_fail <= cf_s_r;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_arm_wait;
        @(posedge smp_clk) disable iff (reset)
        st_r == csq_pkg::CSQ_ARMED && !is_stop && !trg_r |-> !wr;
    endproperty
    a_arm_wait: assert property (p_arm_wait)
        else $error("write while armed without trigger");

    property p_first_addr;
        @(posedge smp_clk) disable iff (reset)
        wr && st_r == csq_pkg::CSQ_ARMED && !is_stop
            |-> ptr_r == csq_pkg::FIRST_ADDR;
    endproperty
    a_first_addr: assert property (p_first_addr)
        else $error("trigger word not at first address");

    property p_stop_end;
        @(posedge smp_clk) disable iff (reset)
        ce_s_l && st_r == csq_pkg::CSQ_ACTIVE && !is_stop && stp_r
            |=> st_r == csq_pkg::CSQ_DONE ##1 st_r == csq_pkg::CSQ_IDLE;
    endproperty
    a_stop_end: assert property (p_stop_end)
        else $error("stop hit did not end the capture");

    property p_stop_arm;
        @(posedge smp_clk) disable iff (reset)
        ce_s_l && st_r == csq_pkg::CSQ_ARMED && is_stop && !trg_r
            |-> wr ##1 st_r == csq_pkg::CSQ_ACTIVE;
    endproperty
    a_stop_arm: assert property (p_stop_arm)
        else $error("stop mode did not go active on first edge");

    property p_trig_last;
        @(posedge smp_clk) disable iff (reset)
        ce_s_l && st_r == csq_pkg::CSQ_ACTIVE && is_stop && trg_r
            |-> wr ##1 (st_r == csq_pkg::CSQ_DONE && !wr);
    endproperty
    a_trig_last: assert property (p_trig_last)
        else $error("trigger word not stored last");

    property p_cmp_nowr;
        @(posedge smp_clk) disable iff (reset)
        is_cmp |-> a_we == 2'h0;
    endproperty
    a_cmp_nowr: assert property (p_cmp_nowr)
        else $error("compare mode wrote memory");

    // Idle may hold a pointer from a run made before a config change.
    property p_cap;
        @(posedge smp_clk) disable iff (reset)
        st_r != csq_pkg::CSQ_IDLE
            |-> ptr_r <= cap_l && (gl_on -> cap_l == CAP_GL);
    endproperty
    a_cap: assert property (p_cap)
        else $error("pointer beyond usable capacity");

    property p_glitch;
        @(posedge smp_clk) disable iff (reset)
        wr && gl_on && csq_pkg::multi_tr(smp_r.tr_up[0])
            |-> a_wdata[W] && a_we == 2'h3;
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("glitch on channel zero not stored");

    property p_defaults;
        @(posedge clk) disable iff (reset)
        ce && load_defaults
            |=> cfg_out.clk_src_ext && !cfg_out.glitch_en;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("defaults not restored");

    property p_cmp_gl;
        @(posedge clk) disable iff (reset)
        cfg_out.mode == csq_pkg::CSQ_CMP |-> !cfg_out.glitch_en;
    endproperty
    a_cmp_gl: assert property (p_cmp_gl)
        else $error("glitch detection on in compare mode");
endmodule : csq_capture_seq

// ### testbench/csq_src.sv
// Pattern source model: link clock, a counting data word and the
// trigger, stop and glitch events. The bench sets the event words.
`timescale 1ns/1ns
module csq_src (
    input wire logic go,
    input wire logic [15:0] trig_at,
    input wire logic [15:0] stop_at,
    input wire logic [15:0] glit_at,
    output logic smp_clk,
    output csq_pkg::csq_smp_s smp_in,
    output logic trig_hit,
    output logic stop_hit,
    output logic [15:0] cnt
);
    // The clock runs gated, only while go is high.
    initial begin
        smp_clk = 1'b0;
        #7;
        forever #16 smp_clk = go ? ~smp_clk : 1'b0;
    end

    // Word counter; each sample differs from its neighbours.
    initial cnt = 16'h0000;
    always @(posedge smp_clk) begin
        cnt <= cnt + 16'h0001;
    end

    // Outside a frame the data shows the inverse, not a held value.
    always_comb begin
        smp_in = '0;
        smp_in.data = go ? cnt : ~cnt;
        smp_in.tr_up[0] = (cnt == glit_at) ? 2'h2 : 2'h0;
        // A lower threshold glitch on channel one in the same period.
        smp_in.tr_lo[1] = (cnt == glit_at) ? 2'h2 : 2'h0;
        trig_hit = go && cnt == trig_at;
        stop_hit = go && cnt == stop_at;
    end
endmodule : csq_src

// ### testbench/tb.sv
// Self-checking bench of the capture sequencer, small build.
// Assumes csq_src stands in for the pattern source.
`timescale 1ns/1ns
module tb;
    logic clk, reset, ce, cfg_wr, load_defaults, run_cmd, host_rd, go;
    csq_pkg::csq_cfg_s cfg_in, cfg_out;
    csq_pkg::csq_state_e status;
    csq_pkg::csq_smp_s smp_in;
    logic [9:0] host_addr;
    logic [15:0] host_rdata, cnt, trig_at, stop_at, glit_at, t, d;
    logic [14:0] stored_words, last_addr;
    logic cmp_fail, smp_clk, trig_hit, stop_hit;
    int n_errors = 0;
    int n_compared = 0;

    csq_capture_seq #(.DEPTH(1024)) DUT (.clk, .reset, .ce, .cfg_wr,
        .cfg_in, .load_defaults, .run_cmd, .host_rd, .host_addr,
        .host_rdata, .cfg_out, .status, .stored_words, .last_addr,
        .cmp_fail, .smp_clk, .smp_in, .trig_hit, .stop_hit);
    csq_src src (.go, .trig_at, .stop_at, .glit_at, .smp_clk, .smp_in,
        .trig_hit, .stop_hit, .cnt);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait; a hang ends the run.
    task automatic wait_state(input csq_pkg::csq_state_e s);
        for (int i = 0; i < 400 && status !== s; i++) @(negedge clk);
        if (status !== s) begin
            n_errors++;
            $display("unexpected at %0t: state timeout", $time);
            tally_and_finish();
        end
    endtask : wait_state

    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clk);
        host_rd <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        d = host_rdata;
    endtask : rd

    task automatic set_cfg(input csq_pkg::csq_mode_e m, input logic g);
        @(posedge clk);
        // Dual threshold goes along with glitch detection here.
        cfg_in <= '{m, g, 1'b1, g};
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask : set_cfg

    // Run, wait for s, trigger 8 words on, stop len words later.
    task automatic run_cap(input csq_pkg::csq_state_e s, input int len);
        @(posedge clk);
        run_cmd <= 1'b1;
        @(posedge clk);
        run_cmd <= 1'b0;
        wait_state(s);
        t = cnt + 16'h0008;
        trig_at <= t;
        glit_at <= t + 16'h0001;
        stop_at <= t + 16'(len);
        wait_state(csq_pkg::CSQ_IDLE);
    endtask : run_cap

    task automatic s_start;
        set_cfg(csq_pkg::CSQ_TRG_START, 1'b0);
        run_cap(csq_pkg::CSQ_ARMED, 5);
        chk(16'(stored_words), 16'h0005);
        rd(10'h000);
        chk(d, t);
        rd(10'h004);
        chk(d, t + 16'h0004);
    endtask : s_start

    task automatic s_stop;
        set_cfg(csq_pkg::CSQ_TRG_STOP, 1'b0);
        run_cap(csq_pkg::CSQ_ACTIVE, 3);
        rd(10'(last_addr));
        chk(d, t);
        rd(10'(last_addr - 15'h0001));
        chk(d, t - 16'h0001);
        go <= 1'b0;
        repeat (20) @(negedge clk);
        chk(16'(status), 16'(csq_pkg::CSQ_IDLE));
        go <= 1'b1;
    endtask : s_stop

    task automatic s_glitch;
        set_cfg(csq_pkg::CSQ_TRG_START, 1'b1);
        run_cap(csq_pkg::CSQ_ARMED, 4);
        rd(10'h001);
        chk(d, 16'h0000);
        chk(16'(stored_words), 16'h0004);
        rd(10'h003);
        chk(d, 16'h0003);
        rd(10'h000);
    endtask : s_glitch

    // Compare after the glitch capture must leave memory alone.
    task automatic s_cmp;
        set_cfg(csq_pkg::CSQ_CMP, 1'b1);
        chk(16'(cfg_out.glitch_en), 16'h0000);
        run_cap(csq_pkg::CSQ_ARMED, 4);
        repeat (8) @(negedge clk);
        chk(16'(cmp_fail), 16'h0001);
        t = d;
        rd(10'h000);
        chk(d, t);
        // Defaults with the enable low must not land.
        @(posedge clk);
        ce <= 1'b0;
        load_defaults <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        @(negedge clk);
        chk(16'(cfg_out), 16'h0013);
        @(posedge clk);
        load_defaults <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(16'(cfg_out), 16'(csq_pkg::CFG_DEFAULT));
    endtask : s_cmp

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        {cfg_wr, load_defaults, run_cmd, host_rd, go} = 5'h01;
        cfg_in = '0;
        host_addr = '0;
        {trig_at, stop_at, glit_at} = '1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(negedge clk);
        chk(16'(status), 16'(csq_pkg::CSQ_IDLE));
        chk(16'(cfg_out), 16'(csq_pkg::CFG_DEFAULT));
        s_start();
        s_stop();
        s_glitch();
        s_cmp();
        tally_and_finish();
    end
endmodule : tb
